// ### motor_start_consts.svh
`ifndef MOTOR_START_CONSTS_SVH
`define MOTOR_START_CONSTS_SVH
// Clock rate
`define CLK_HZ 50000000
`define CLK_KHZ 50000
// Brake timeout in ms and derived cycles
`define BRAKE_TIME_MS 5000
`define BRAKE_CYCLES (`BRAKE_TIME_MS * `CLK_KHZ)
// Longest align time in ms and derived cycles
`define ALIGN_TIME_MS 670
`define ALIGN_CYCLES (`ALIGN_TIME_MS * `CLK_KHZ)
// Stationary threshold in Hz; a longer period than this means stopped
`define STILL_FREQ_HZ 10
`define STILL_CYCLES (`CLK_HZ / `STILL_FREQ_HZ)
// Lock-off delay in ms and derived cycles
`define LOCKOFF_TIME_MS 5000
`define LOCKOFF_CYCLES (`LOCKOFF_TIME_MS * `CLK_KHZ)
// Align current slew in mA per second, cycles per 1 mA step
`define ALIGN_SLEW_MA_PER_S 12000
`define ALIGN_STEP_CYCLES (`CLK_HZ / `ALIGN_SLEW_MA_PER_S)
// Open-loop ramp update tick of 1 ms
`define RAMP_TICK_CYCLES `CLK_KHZ
// Current ceiling step, top-code cap while aligning, in mA
`define ILIM_STEP_MA 11'h0c8
`define ILIM_ALIGN_CAP_MA 11'h5dc
`define ILIM_TOP_CODE 3'h7
// Synchroniser vector bit positions
`define SY_PHU 0
`define SY_SC 1
`define SY_TRIP 2
`define SY_REL 3
`define SY_UVR 4
`define SY_UVF 5
`define SY_LPR 6
`define SY_W 7
`endif

// ### motor_start_pkg.sv
package motor_start_pkg;
	typedef enum logic [3:0] {
		ST_LOW_POWER,
		ST_SPEED_DETECT,
		ST_BRAKE,
		ST_ALIGN,
		ST_OPEN_LOOP,
		ST_COAST,
		ST_CLOSED_LOOP,
		ST_SPIN_DOWN,
		ST_LOCK_OFF,
		ST_FAULT_OFF
	} seq_state_e;
endpackage

// ### motor_start_protect.sv
// Behaviour
// [R1] Closed loop: lock if a commutation period is under half the previous one.
// [R2] Lock if calculated BEMF exceeds 1.5x phase U voltage for a whole electrical period.
// [R3] Soft current limit only in closed loop; it never faults nor stops drive.
// [R4] Voltage cap is ceiling times resistance plus speed times BEMF constant.
// [R5] Ceiling code gives 200..1600 mA in 200 mA steps; top is 1500 aligning.
// [R6] Short-circuit indication sends all phases to high impedance at once.
// [R7] After short circuit clears, rerun initialization and restart the motor.
// [R8] Over-temperature stops the motor until the release indication shows it cooled.
// [R9] Run only after supply passes the rising level; stop below falling level.
// [R10] On leaving low power check spin; under 10 Hz means stationary.
// [R11] If spinning, brake until stationary or 5 s timeout, whichever first.
// [R12] Align drives V and W equally for run current on U, at most 0.67 s.
// [R13] Align current ramps gradually at about 12 A/s.
// [R14] Open loop starts after stationary and align; ramps rate without position feedback.
// [R15] Ramp code selects open-loop linear and quadratic acceleration terms.
// [R16] Ramp code selects closed-loop acceleration and deceleration times.
// [R17] Any lock: phases high impedance, wait lock-off delay, then restart.
// [R18] At handoff BEMF coast one electrical cycle, then enter closed loop.
// [R19] Spin-down mirrors phase U comparator on feedback; under 10 Hz low power, output high.
// [R20] One sequencer; undervoltage, thermal and short circuit override every state.
`timescale 1ns/100ps
`default_nettype none
`include "motor_start_consts.svh"
module sensorless_motor_start_protect #(
	parameter int unsigned BRAKE_CYC = `BRAKE_CYCLES,
	parameter int unsigned ALIGN_CYC = `ALIGN_CYCLES,
	parameter int unsigned STILL_CYC = `STILL_CYCLES,
	parameter int unsigned LOCKOFF_CYC = `LOCKOFF_CYCLES,
	parameter int unsigned ALIGN_STEP_CYC = `ALIGN_STEP_CYCLES,
	parameter int unsigned RAMP_TICK_CYC = `RAMP_TICK_CYCLES
) (
	input wire logic mclk_i, // System clock
	input wire logic sys_rst_i, // Synchronous reset, high
	input wire logic phase_u_cmp_i, // Phase U comparator, async
	input wire logic short_circuit_i, // Phase current over threshold, async
	input wire logic thermal_trip_i, // Junction above trip level, async
	input wire logic thermal_release_i, // Below trip minus hysteresis, async
	input wire logic supply_above_rise_i, // Supply above fall level plus hysteresis, async
	input wire logic supply_below_fall_i, // Supply below fall level, async
	input wire logic low_power_req_i, // Speed command asks for low power, async
	input wire logic [3:0] ramp_profile_select_i, // Acceleration profile code
	input wire logic [2:0] ilim_select_i, // Current ceiling code
	input wire logic [10:0] run_current_i, // Closed-loop run current, mA
	input wire logic [15:0] winding_resistance_i, // Measured resistance, mOhm
	input wire logic [15:0] bemf_constant_i, // Measured constant, uV/Hz
	input wire logic [15:0] speed_i, // Electrical speed, Hz
	input wire logic [31:0] bemf_calc_i, // Calculated BEMF, uV
	input wire logic [31:0] phase_u_volt_i, // Applied phase U voltage, uV
	input wire logic [31:0] duty_volt_i, // Commanded phase voltage, uV
	input wire logic comm_event_i, // Closed-loop commutation pulse
	input wire logic elec_period_i, // Electrical period end pulse
	input wire logic handoff_reached_i, // Open-loop BEMF at handoff level
	output motor_start_pkg::seq_state_e state_o, // Sequencer state
	output logic phase_hiz_o, // All phases high impedance
	output logic brake_o, // Brake the rotor
	output logic align_vw_equal_o, // Drive V and W equally
	output logic [10:0] align_current_o, // Align current target, mA
	output logic [10:0] ilim_ma_o, // Current ceiling, mA
	output logic [31:0] drive_volt_o, // Phase U drive voltage, uV
	output logic soft_limit_hit_o, // Soft limit capping drive
	output logic [31:0] ol_rate_o, // Open-loop commutation rate, 1e-5 Hz
	output logic [12:0] ol_accel_lin_o, // Linear term, 0.01 Hz/s
	output logic [11:0] ol_accel_quad_o, // Quadratic term, 0.01 Hz/s^2
	output logic [7:0] cl_accel_time_o, // Closed-loop accel time, 0.1 s
	output logic [8:0] cl_decel_time_o, // Closed-loop decel time, 0.1 s
	output logic speed_feedback_output_o, // Speed feedback pin level
	output logic lock_o // One-cycle lock detection pulse
);
	import motor_start_pkg::*;

	// ************************************************************
	// Decode functions
	// ************************************************************
	// Linear open-loop term per ramp code, 0.01 Hz/s
	function automatic logic [12:0] lin_term(input logic [3:0] c);
		case (c)
			4'h0, 4'hf: lin_term = 13'h01cc;
			4'h1, 4'he: lin_term = 13'h0398;
			4'h2, 4'hd: lin_term = 13'h05dc;
			4'h3, 4'h4, 4'hb, 4'hc: lin_term = 13'h09c4;
			4'h5, 4'ha: lin_term = 13'h0dac;
			4'h6, 4'h9: lin_term = 13'h1388;
			default: lin_term = 13'h1d4c;
		endcase
	endfunction

	// Quadratic open-loop term per ramp code, 0.01 Hz/s^2
	function automatic logic [11:0] quad_term(input logic [3:0] c);
		case (c)
			4'h0, 4'hf: quad_term = 12'h016;
			4'h1, 4'h2, 4'hd, 4'he: quad_term = 12'h0a5;
			4'h3, 4'hc: quad_term = 12'h14a;
			4'h4, 4'h5, 4'ha, 4'hb: quad_term = 12'h2bc;
			4'h6, 4'h9: quad_term = 12'h578;
			default: quad_term = 12'ha8c;
		endcase
	endfunction

	// Closed-loop full-scale acceleration time, 0.1 s
	function automatic logic [7:0] acc_time(input logic [3:0] c);
		case (c)
			4'h0, 4'h1: acc_time = 8'h1b;
			4'h2, 4'h3: acc_time = 8'h0a;
			4'h4, 4'h5, 4'h6, 4'h7: acc_time = 8'h02;
			4'h8, 4'hc: acc_time = 8'h36;
			4'h9, 4'hd: acc_time = 8'h50;
			4'ha, 4'he: acc_time = 8'h6e;
			default: acc_time = 8'hdc;
		endcase
	endfunction

	// Closed-loop full-scale deceleration time, 0.1 s
	function automatic logic [8:0] dec_time(input logic [3:0] c);
		case (c)
			4'h0, 4'h4, 4'hb, 4'hf: dec_time = 9'h1b8;
			4'h3, 4'h7, 4'h8, 4'hc: dec_time = 9'h06e;
			default: dec_time = 9'h0dc;
		endcase
	endfunction

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [`SY_W-1:0] sync_a_r;
	logic [`SY_W-1:0] sync_b_r;
	logic phu_prev_r;
	// Two flops for every pin-side input
	always_ff @(posedge mclk_i) begin
		sync_a_r <= {low_power_req_i, supply_below_fall_i, supply_above_rise_i,
			thermal_release_i, thermal_trip_i, short_circuit_i, phase_u_cmp_i};
		sync_b_r <= sync_a_r;
		phu_prev_r <= sync_b_r[`SY_PHU];
	end

	wire logic phu_rise = sync_b_r[`SY_PHU] & ~phu_prev_r;
	wire logic sc_now = sync_b_r[`SY_SC];

	// ************************************************************
	// Protection flags
	// ************************************************************
	logic supply_ok_r;
	logic hot_r;
	// Undervoltage hysteresis: falling level wins over rising
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			supply_ok_r <= 1'b0;
		end else if (sync_b_r[`SY_UVF]) begin
			supply_ok_r <= 1'b0; // [R9]
		end else if (sync_b_r[`SY_UVR]) begin
			supply_ok_r <= 1'b1; // [R9]
		end
	end

	// Thermal latch: trip sets, qualified release clears
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			hot_r <= 1'b0;
		end else if (sync_b_r[`SY_TRIP]) begin
			hot_r <= 1'b1; // [R8]
		end else if (sync_b_r[`SY_REL]) begin
			hot_r <= 1'b0; // [R8]
		end
	end

	wire logic fault_now = sc_now | hot_r | ~supply_ok_r;

	// ************************************************************
	// Rotor speed sensing on phase U edges
	// ************************************************************
	logic [27:0] edge_cnt_r;
	logic still_r;
	logic spin_edge_r;
	// Period between rising edges; too long means stationary
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			edge_cnt_r <= '0;
			still_r <= 1'b1;
			spin_edge_r <= 1'b0;
		end else begin
			spin_edge_r <= phu_rise && (edge_cnt_r < 28'(STILL_CYC)); // [R10]
			if (phu_rise) begin
				edge_cnt_r <= '0;
				still_r <= (edge_cnt_r >= 28'(STILL_CYC));
			end else if (edge_cnt_r >= 28'(STILL_CYC)) begin
				still_r <= 1'b1; // [R10]
			end else begin
				edge_cnt_r <= edge_cnt_r + 28'h1;
			end
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	seq_state_e state_r;
	logic [27:0] tmr_r;
	logic lock_req;
	wire logic tmr_zero = (tmr_r == 28'h0);

	// Single state machine; faults override every state
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_r <= ST_FAULT_OFF;
			tmr_r <= '0;
		end else if (fault_now) begin
			state_r <= ST_FAULT_OFF; // [R20] [R6] [R8] [R9]
		end else begin
			if (!tmr_zero) begin
				tmr_r <= tmr_r - 28'h1;
			end
			unique case (state_r)
				ST_FAULT_OFF: begin
					state_r <= ST_SPEED_DETECT; // [R7]
				end
				ST_LOW_POWER: begin
					if (!sync_b_r[`SY_LPR]) begin
						state_r <= ST_SPEED_DETECT; // [R10]
					end
				end
				ST_SPEED_DETECT: begin
					tmr_r <= 28'(BRAKE_CYC);
					if (spin_edge_r) begin
						state_r <= ST_BRAKE; // [R11]
					end else if (still_r) begin
						state_r <= ST_ALIGN; // [R14]
						tmr_r <= 28'(ALIGN_CYC);
					end
				end
				ST_BRAKE: begin
					if (still_r || tmr_zero) begin
						state_r <= ST_ALIGN; // [R11]
						tmr_r <= 28'(ALIGN_CYC);
					end
				end
				ST_ALIGN: begin
					if (tmr_zero) begin
						state_r <= ST_OPEN_LOOP; // [R12] [R14]
					end
				end
				ST_OPEN_LOOP: begin
					if (handoff_reached_i) begin
						state_r <= ST_COAST; // [R18]
					end
				end
				ST_COAST: begin
					if (elec_period_i) begin
						state_r <= ST_CLOSED_LOOP; // [R18]
					end
				end
				ST_CLOSED_LOOP: begin
					if (lock_req) begin
						state_r <= ST_LOCK_OFF; // [R17]
						tmr_r <= 28'(LOCKOFF_CYC);
					end else if (sync_b_r[`SY_LPR]) begin
						state_r <= ST_SPIN_DOWN; // [R19]
					end
				end
				ST_SPIN_DOWN: begin
					if (still_r) begin
						state_r <= ST_LOW_POWER; // [R19]
					end
				end
				ST_LOCK_OFF: begin
					if (tmr_zero) begin
						state_r <= ST_SPEED_DETECT; // [R17]
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Lock detectors
	// ************************************************************
	logic [31:0] cp_cnt_r;
	logic [31:0] cp_prev_r;
	logic cp_valid_r;
	logic bemf_high_r;
	wire logic in_cl = (state_r == ST_CLOSED_LOOP);
	wire logic bemf_over = ({1'b0, bemf_calc_i, 1'b0} > ({2'b00, phase_u_volt_i} +
		{1'b0, phase_u_volt_i, 1'b0}));
	wire logic cl_abn = comm_event_i && cp_valid_r && ({cp_cnt_r, 1'b0} < {1'b0, cp_prev_r});
	wire logic spd_abn = elec_period_i && bemf_high_r;
	assign lock_req = in_cl && (cl_abn || spd_abn);

	// Commutation period compare against the previous period
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !in_cl) begin
			cp_cnt_r <= '0;
			cp_prev_r <= '0;
			cp_valid_r <= 1'b0;
		end else if (comm_event_i) begin
			cp_prev_r <= cp_cnt_r; // [R1]
			cp_cnt_r <= '0;
			cp_valid_r <= 1'b1;
		end else if (cp_cnt_r != 32'hffffffff) begin
			cp_cnt_r <= cp_cnt_r + 32'h1;
		end
	end

	// BEMF over 1.5x phase U for the whole period since last period end
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !in_cl) begin
			bemf_high_r <= 1'b0;
		end else if (elec_period_i) begin
			bemf_high_r <= bemf_over; // [R2]
		end else if (!bemf_over) begin
			bemf_high_r <= 1'b0; // [R2]
		end
	end

	// Lock pulse
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			lock_o <= 1'b0;
		end else begin
			lock_o <= lock_req && !fault_now; // [R1] [R2]
		end
	end

	// ************************************************************
	// Current ceiling and soft limit
	// ************************************************************
	wire logic aligning = (state_r == ST_ALIGN);
	wire logic [10:0] ilim_now = (aligning && ilim_select_i == `ILIM_TOP_CODE) ?
		`ILIM_ALIGN_CAP_MA : 11'(({8'h00, ilim_select_i} + 11'h1) * `ILIM_STEP_MA);
	wire logic [32:0] vcap = ({22'h0, ilim_now} * {17'h0, winding_resistance_i}) +
		({17'h0, speed_i} * {17'h0, bemf_constant_i});
	wire logic capped = in_cl && ({1'b0, duty_volt_i} > vcap);

	// Registered ceiling and drive voltage
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ilim_ma_o <= '0;
			drive_volt_o <= '0;
			soft_limit_hit_o <= 1'b0;
		end else begin
			ilim_ma_o <= ilim_now; // [R5]
			soft_limit_hit_o <= capped; // [R3]
			drive_volt_o <= capped ? vcap[31:0] : duty_volt_i; // [R3] [R4]
		end
	end

	// ************************************************************
	// Align current ramp
	// ************************************************************
	logic [12:0] step_cnt_r;
	// 1 mA steps towards the run current
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !aligning) begin
			step_cnt_r <= '0;
			align_current_o <= '0;
		end else if (step_cnt_r >= 13'(ALIGN_STEP_CYC - 1)) begin
			step_cnt_r <= '0;
			if (align_current_o < run_current_i) begin
				align_current_o <= align_current_o + 11'h1; // [R13]
			end else if (align_current_o > run_current_i) begin
				align_current_o <= align_current_o - 11'h1; // [R13]
			end
		end else begin
			step_cnt_r <= step_cnt_r + 13'h1;
		end
	end

	// ************************************************************
	// Open-loop rate ramp
	// ************************************************************
	logic [15:0] tick_cnt_r;
	logic [31:0] quad_acc_r;
	wire logic ol = (state_r == ST_OPEN_LOOP);
	// Every 1 ms add linear plus growing quadratic term; no position used
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !ol) begin
			tick_cnt_r <= '0;
			quad_acc_r <= '0;
			ol_rate_o <= '0;
		end else if (tick_cnt_r >= 16'(RAMP_TICK_CYC - 1)) begin
			tick_cnt_r <= '0;
			quad_acc_r <= quad_acc_r + {20'h0, ol_accel_quad_o}; // [R15]
			ol_rate_o <= ol_rate_o + {19'h0, ol_accel_lin_o} + {10'h0, quad_acc_r[31:10]}; // [R14]
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h1;
		end
	end

	// Profile decode, registered
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ol_accel_lin_o <= '0;
			ol_accel_quad_o <= '0;
			cl_accel_time_o <= '0;
			cl_decel_time_o <= '0;
		end else begin
			ol_accel_lin_o <= lin_term(ramp_profile_select_i); // [R15]
			ol_accel_quad_o <= quad_term(ramp_profile_select_i); // [R15]
			cl_accel_time_o <= acc_time(ramp_profile_select_i); // [R16]
			cl_decel_time_o <= dec_time(ramp_profile_select_i); // [R16]
		end
	end

	// ************************************************************
	// Phase drive and feedback outputs
	// ************************************************************
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_o <= ST_FAULT_OFF;
			phase_hiz_o <= 1'b1;
			brake_o <= 1'b0;
			align_vw_equal_o <= 1'b0;
			speed_feedback_output_o <= 1'b1;
		end else begin
			state_o <= state_r;
			phase_hiz_o <= fault_now || lock_req || (state_r inside {ST_FAULT_OFF,
				ST_LOCK_OFF, ST_LOW_POWER, ST_SPEED_DETECT, ST_COAST, ST_SPIN_DOWN}); // [R6] [R17]
			brake_o <= !fault_now && (state_r == ST_BRAKE); // [R11]
			align_vw_equal_o <= !fault_now && aligning; // [R12]
			speed_feedback_output_o <= (state_r == ST_LOW_POWER) ? 1'b1 : sync_b_r[`SY_PHU]; // [R19]
		end
	end
endmodule
`default_nettype wire

// ### motor_phase_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Rotor phase U comparator model
// ****************************************
module motor_phase_model (
	input wire logic clk_i, // System clock
	input wire logic [15:0] half_per_i, // Half electrical period in cycles, zero when still
	output logic cmp_o // Phase U comparator level
);
	logic [15:0] cnt_r;
	// Start from a known level so the synchroniser never sees an unknown
	initial begin
		cnt_r = 16'h0;
		cmp_o = 1'b0;
	end
	// A still rotor leaves the comparator at its last level
	always @(posedge clk_i) begin
		if (half_per_i == 16'h0 || cnt_r >= half_per_i - 16'h1) begin
			cnt_r <= 16'h0;
		end else begin
			cnt_r <= cnt_r + 16'h1;
		end
		if (half_per_i != 16'h0 && cnt_r >= half_per_i - 16'h1) begin
			cmp_o <= ~cmp_o;
		end
	end
endmodule
`default_nettype wire

// ### start_protect_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checks of the start and protection sequencer
// ****************************************
module start_protect_checker (
	input wire logic mclk_i, // System clock
	input wire logic sys_rst_i, // Reset
	input wire logic short_circuit_i, // Short circuit
	input wire logic thermal_trip_i, // Over temperature
	input wire logic supply_below_fall_i, // Supply low
	input wire logic [2:0] ilim_select_i, // Ceiling code
	input wire logic [31:0] duty_volt_i, // Commanded voltage
	input var motor_start_pkg::seq_state_e state_o, // State
	input wire logic phase_hiz_o, // Phases off
	input wire logic brake_o, // Brake
	input wire logic align_vw_equal_o, // Align drive
	input wire logic [10:0] ilim_ma_o, // Ceiling
	input wire logic [31:0] drive_volt_o, // Drive voltage
	input wire logic soft_limit_hit_o, // Soft limit
	input wire logic speed_feedback_output_o, // Feedback pin
	input wire logic lock_o // Lock pulse
);
	import motor_start_pkg::*;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// Fault and lock handling
	a_fault_phases_off: assert property (state_o == ST_FAULT_OFF |-> phase_hiz_o)
		else $error("phases driven while off");
	a_short_phases_off: assert property (short_circuit_i [*5] |-> phase_hiz_o)
		else $error("short circuit left phases driven");
	a_thermal_stop: assert property (thermal_trip_i [*6] |-> state_o == ST_FAULT_OFF)
		else $error("running while hot");
	a_undervolt_stop: assert property (supply_below_fall_i [*6] |-> state_o == ST_FAULT_OFF)
		else $error("running at low supply");
	a_lock_goes_off: assert property (lock_o |-> ##[0:3] (state_o == ST_LOCK_OFF && phase_hiz_o))
		else $error("lock did not switch phases off");
	a_lockoff_holds: assert property ($rose(state_o == ST_LOCK_OFF) |-> (state_o == ST_LOCK_OFF) [*8])
		else $error("lock-off left early");
	// Current ceiling and soft limit
	a_ceiling_code: assert property (state_o == ST_CLOSED_LOOP && $stable(ilim_select_i)
		|-> ilim_ma_o == (11'(ilim_select_i) + 11'h1) * 11'h0c8)
		else $error("ceiling decode wrong");
	a_align_ceiling: assert property (state_o == ST_ALIGN && ilim_select_i == 3'h7
		&& $stable(ilim_select_i) |-> ilim_ma_o == 11'h5dc)
		else $error("align ceiling not reduced");
	a_soft_caps: assert property (soft_limit_hit_o |-> drive_volt_o < $past(duty_volt_i))
		else $error("soft limit did not cap");
	a_soft_state: assert property (soft_limit_hit_o |-> state_o == ST_CLOSED_LOOP)
		else $error("soft limit outside closed loop");
	// Align, brake and feedback outputs
	a_align_drive: assert property (state_o == ST_ALIGN && !phase_hiz_o
		|-> align_vw_equal_o && !brake_o)
		else $error("align drive wrong");
	a_brake_state: assert property (brake_o |-> state_o == ST_BRAKE)
		else $error("brake outside braking");
	a_low_power_fb: assert property (state_o == ST_LOW_POWER |-> speed_feedback_output_o)
		else $error("feedback low in low power");
	c_closed: cover property (state_o == ST_CLOSED_LOOP);
	c_soft: cover property (soft_limit_hit_o);
	c_brake: cover property (state_o == ST_BRAKE);
	c_lock: cover property (lock_o);
endmodule
`default_nettype wire

// ### sensorless_motor_start_protect_test.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Sequencer test bench
// ****************************************
module sensorless_motor_start_protect_test;
	import motor_start_pkg::*;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, short_circuit_i = 1'b0, thermal_trip_i = 1'b0;
	logic thermal_release_i = 1'b1, supply_above_rise_i = 1'b0, supply_below_fall_i = 1'b0;
	logic low_power_req_i = 1'b0, comm_event_i = 1'b0, elec_period_i = 1'b0;
	logic handoff_reached_i = 1'b0, phase_u_cmp_i;
	logic [3:0] ramp_profile_select_i = 4'h0;
	logic [2:0] ilim_select_i = 3'h7;
	logic [10:0] run_current_i = 11'h12c;
	logic [15:0] winding_resistance_i = 16'h3e8, bemf_constant_i = 16'h3e8, speed_i = 16'h000a;
	logic [31:0] bemf_calc_i = 32'h0, phase_u_volt_i = 32'h64, duty_volt_i = 32'h0;
	logic [15:0] half_per = 16'h0;
	seq_state_e state_o;
	logic phase_hiz_o, brake_o, align_vw_equal_o, soft_limit_hit_o, speed_feedback_output_o, lock_o;
	logic [10:0] align_current_o, ilim_ma_o;
	logic [31:0] drive_volt_o, ol_rate_o;
	logic [12:0] ol_accel_lin_o;
	logic [11:0] ol_accel_quad_o;
	logic [7:0] cl_accel_time_o;
	logic [8:0] cl_decel_time_o;
	int mismatches = 0, cmp_count = 0, ticks = 0;
	// Expected decode; open-loop terms mirror
	logic [12:0] lin_t [8] = '{13'h1cc, 13'h398, 13'h5dc, 13'h9c4, 13'h9c4, 13'hdac, 13'h1388,
		13'h1d4c};
	logic [11:0] quad_t [8] = '{12'h16, 12'ha5, 12'ha5, 12'h14a, 12'h2bc, 12'h2bc, 12'h578, 12'ha8c};
	logic [7:0] acc_t [16] = '{8'h1b, 8'h1b, 8'ha, 8'ha, 8'h2, 8'h2, 8'h2, 8'h2, 8'h36, 8'h50,
		8'h6e, 8'hdc, 8'h36, 8'h50, 8'h6e, 8'hdc};
	logic [8:0] dec_t [16] = '{9'h1b8, 9'hdc, 9'hdc, 9'h6e, 9'h1b8, 9'hdc, 9'hdc, 9'h6e, 9'h6e,
		9'hdc, 9'hdc, 9'h1b8, 9'h6e, 9'hdc, 9'hdc, 9'h1b8};

	sensorless_motor_start_protect #(.BRAKE_CYC(2000), .ALIGN_CYC(1000), .STILL_CYC(200),
		.LOCKOFF_CYC(500), .ALIGN_STEP_CYC(4), .RAMP_TICK_CYC(10)) u_sensorless_motor_start_protect (.*);
	motor_phase_model u_motor_phase_model (.clk_i(mclk_i), .half_per_i(half_per),
		.cmp_o(phase_u_cmp_i));

	// 50 MHz clock
	always #10 mclk_i = ~mclk_i;
	// Hang guard
	always @(posedge mclk_i) begin
		ticks++;
		if (ticks == 20000) begin
			mismatches++;
			finish_test;
		end
	end

	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Let n edges pass, then look at settled outputs
	task settle(input int n);
		repeat (n) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask
	task wait_st(input seq_state_e s, input int lim, output int n);
		n = 0;
		while (state_o !== s && n < lim) begin
			@(negedge mclk_i);
			n++;
		end
		chk(state_o, s);
	endtask
	task comm(input int gap);
		repeat (gap) @(posedge mclk_i);
		comm_event_i <= 1'b1;
		@(posedge mclk_i) comm_event_i <= 1'b0;
	endtask
	task epulse(input int gap);
		repeat (gap) @(posedge mclk_i);
		elec_period_i <= 1'b1;
		@(posedge mclk_i) elec_period_i <= 1'b0;
	endtask
	// Speed detect through align and open loop into closed loop
	task run_up;
		int n;
		logic [31:0] r;
		wait_st(ST_ALIGN, 2300, n);
		settle(40);
		chk(align_vw_equal_o, 1'b1);
		chk(ilim_ma_o, 11'h5dc);
		chk(align_current_o > 11'h5 && align_current_o < 11'h14, 1'b1);
		wait_st(ST_OPEN_LOOP, 1000, n);
		chk(n > 940, 1'b1);
		r = ol_rate_o;
		settle(50);
		chk(ol_rate_o > r, 1'b1);
		@(posedge mclk_i) handoff_reached_i <= 1'b1;
		@(posedge mclk_i) handoff_reached_i <= 1'b0;
		wait_st(ST_COAST, 10, n);
		epulse(5);
		wait_st(ST_CLOSED_LOOP, 10, n);
		settle(2);
		chk(ilim_ma_o, 11'h640);
	endtask

	initial begin
		int n;
		logic p;
		repeat (20) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		// Ramp and ceiling decode while held off
		for (int i = 0; i < 16; i++) begin
			@(posedge mclk_i) ramp_profile_select_i <= 4'(i);
			settle(2);
			chk(ol_accel_lin_o, lin_t[i < 8 ? i : 15 - i]);
			chk(ol_accel_quad_o, quad_t[i < 8 ? i : 15 - i]);
			chk(cl_accel_time_o, acc_t[i]);
			chk(cl_decel_time_o, dec_t[i]);
		end
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk_i) ilim_select_i <= 3'(i);
			settle(2);
			chk(ilim_ma_o, 11'(i + 1) * 11'h0c8);
		end
		chk(state_o, ST_FAULT_OFF);
		chk(phase_hiz_o, 1'b1);
		@(posedge mclk_i) supply_above_rise_i <= 1'b1;
		wait_st(ST_SPEED_DETECT, 10, n);
		run_up;
		// Soft limit: 200 mA * 2 Ohm + 20 Hz * 1 mV/Hz = 420 mV
		@(posedge mclk_i);
		ilim_select_i <= 3'h0;
		winding_resistance_i <= 16'h7d0;
		speed_i <= 16'h14;
		duty_volt_i <= 32'h7a120;
		settle(3);
		chk(drive_volt_o, 32'h668a0);
		chk(soft_limit_hit_o, 1'b1);
		chk(state_o, ST_CLOSED_LOOP);
		@(posedge mclk_i) duty_volt_i <= 32'h186a0;
		ilim_select_i <= 3'h7;
		settle(3);
		chk(drive_volt_o, 32'h186a0);
		chk(soft_limit_hit_o, 1'b0);
		// Period exactly half is no lock, shorter is
		repeat (3) comm(40);
		comm(20);
		settle(3);
		chk(state_o, ST_CLOSED_LOOP);
		comm(5);
		wait_st(ST_LOCK_OFF, 10, n);
		chk(phase_hiz_o, 1'b1);
		@(posedge mclk_i) half_per <= 16'h14;
		wait_st(ST_SPEED_DETECT, 520, n);
		chk(n > 480, 1'b1);
		wait_st(ST_BRAKE, 100, n);
		settle(1);
		chk(brake_o, 1'b1);
		wait_st(ST_ALIGN, 2100, n);
		chk(n > 1900, 1'b1);
		@(posedge mclk_i) half_per <= 16'h0;
		run_up;
		// BEMF at exactly 1.5x phase U is no lock, above it is
		@(posedge mclk_i) bemf_calc_i <= 32'h96;
		epulse(10);
		epulse(10);
		settle(3);
		chk(state_o, ST_CLOSED_LOOP);
		@(posedge mclk_i) bemf_calc_i <= 32'h97;
		epulse(10);
		epulse(10);
		wait_st(ST_LOCK_OFF, 10, n);
		@(posedge mclk_i) bemf_calc_i <= 32'h0;
		half_per <= 16'h14;
		wait_st(ST_BRAKE, 620, n);
		settle(50);
		@(posedge mclk_i) half_per <= 16'h0;
		wait_st(ST_ALIGN, 260, n);
		run_up;
		// Spin-down mirrors the comparator, then low power holds feedback high
		@(posedge mclk_i) half_per <= 16'h14;
		repeat (100) @(posedge mclk_i);
		low_power_req_i <= 1'b1;
		wait_st(ST_SPIN_DOWN, 10, n);
		p = speed_feedback_output_o;
		n = 0;
		repeat (100) begin
			@(negedge mclk_i);
			if (speed_feedback_output_o !== p) n++;
			p = speed_feedback_output_o;
		end
		chk(n > 3, 1'b1);
		@(posedge mclk_i) half_per <= 16'h0;
		wait_st(ST_LOW_POWER, 260, n);
		settle(2);
		chk(speed_feedback_output_o, 1'b1);
		@(posedge mclk_i) low_power_req_i <= 1'b0;
		wait_st(ST_SPEED_DETECT, 10, n);
		wait_st(ST_ALIGN, 260, n);
		// Short circuit in mid-align
		@(posedge mclk_i) short_circuit_i <= 1'b1;
		settle(5);
		chk(phase_hiz_o, 1'b1);
		wait_st(ST_FAULT_OFF, 5, n);
		@(posedge mclk_i) short_circuit_i <= 1'b0;
		wait_st(ST_SPEED_DETECT, 10, n);
		wait_st(ST_ALIGN, 260, n);
		// Over temperature waits for the release indication
		@(posedge mclk_i) thermal_trip_i <= 1'b1;
		thermal_release_i <= 1'b0;
		wait_st(ST_FAULT_OFF, 8, n);
		@(posedge mclk_i) thermal_trip_i <= 1'b0;
		settle(20);
		chk(state_o, ST_FAULT_OFF);
		@(posedge mclk_i) thermal_release_i <= 1'b1;
		wait_st(ST_SPEED_DETECT, 10, n);
		// Undervoltage waits for the rising level
		@(posedge mclk_i) supply_below_fall_i <= 1'b1;
		supply_above_rise_i <= 1'b0;
		wait_st(ST_FAULT_OFF, 8, n);
		@(posedge mclk_i) supply_below_fall_i <= 1'b0;
		settle(20);
		chk(state_o, ST_FAULT_OFF);
		@(posedge mclk_i) supply_above_rise_i <= 1'b1;
		wait_st(ST_SPEED_DETECT, 10, n);
		finish_test;
	end
endmodule
bind sensorless_motor_start_protect start_protect_checker u_start_protect_checker (.*);
`default_nettype wire
